// File: uhfc_uart.v
// Flow-controlled UART: two port instances, each with TX FIFO and RX FIFO
//
// What this block does
// - Baud up to one megabit per second; flow control done in hardware.
// - Optional ninth parity bit generated on transmit, checked on receive.
// - Request-to-send driven out, clear-to-send sampled in, both active low.
// - Data lines idle high; low flow-control level means asserted.
// - Host transmit feeds device receive; device transmit feeds host receive.
// - After reset the transmit pin is an output driven high.
// - After reset the receive pin is an input with pull-up enabled.
// - After reset request-to-send driven low; clear-to-send input pulled down.
// - Framing and handshake interoperate with standard UART controllers.
`timescale 1ns/10ps
`default_nettype none
`include "uhfc_defs.vh"

// -----------------------------------------------------------------
// Small FIFO
// -----------------------------------------------------------------
module uhfc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `UHFC_FIFO_DEPTH,
  parameter AW    = `UHFC_FIFO_AW
) (
  input  wire             mclk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp;
  reg [AW-1:0]    rp;
  reg [AW:0]      cnt;
  wire            push = in_valid && in_ready;
  wire            pop  = out_valid && out_ready;
  assign in_ready  = (cnt != DEPTH[AW:0]);
  assign out_valid = (cnt != {(AW+1){1'b0}});
  assign out_data  = mem[rp];
  always @(posedge mclk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wp  <= {AW{1'b0}};
      rp  <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp <= (wp == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp + 1'b1;
      end
      if (push && !pop) begin
        cnt <= cnt + 1'b1;
      end else if (pop && !push) begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule // uhfc_fifo

// -----------------------------------------------------------------
// One serial port
// -----------------------------------------------------------------
module uhfc_port #(
  parameter DIV_W = `UHFC_DIV_W
) (
  input  wire             mclk,
  input  wire             rst_n,
  input  wire [DIV_W-1:0] baud_div,
  input  wire             parity_en,
  input  wire             parity_odd,
  input  wire [7:0]       tx_data,
  input  wire             tx_valid,
  output wire             tx_ready,
  output reg  [8:0]       rx_data,
  output reg              rx_valid,
  input  wire             rx_ready,
  output reg              ser_tx,
  output wire             ser_tx_oe,
  input  wire             ser_rx,
  output wire             ser_rx_pu,
  output reg              rts_n,
  input  wire             cts_n,
  output wire             cts_pd
);
  localparam S_IDLE = 4'h1;
  localparam S_STRT = 4'h2;
  localparam S_DATA = 4'h4;
  localparam S_STOP = 4'h8;

  assign ser_tx_oe = 1'b1;
  assign ser_rx_pu = 1'b1;
  assign cts_pd    = 1'b1;

  // -----------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------
  reg [1:0] rx_s;
  reg [1:0] cts_s;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s  <= 2'h3;  // Idle level
      cts_s <= 2'h0;
    end else begin
      rx_s  <= {rx_s[0], ser_rx};
      cts_s <= {cts_s[0], cts_n};
    end
  end
  wire rxd = rx_s[1];
  wire cts_ok = !cts_s[1];

  // -----------------------------------------------------------------
  // Transmit FIFO and shifter
  // -----------------------------------------------------------------
  wire [7:0] tf_data;
  wire       tf_valid;
  reg        tf_take;
  uhfc_fifo #(.WIDTH(8)) u_txf (
    .mclk(mclk), .rst_n(rst_n),
    .in_data(tx_data), .in_valid(tx_valid), .in_ready(tx_ready),
    .out_data(tf_data), .out_valid(tf_valid), .out_ready(tf_take)
  );

  reg [3:0]       t_st;
  reg [DIV_W-1:0] t_cnt;
  reg [3:0]       t_bit;
  reg [8:0]       t_sh;
  wire            t_tick = (t_cnt == {DIV_W{1'b0}});
  wire [3:0]      t_last = parity_en ? `UHFC_PAR_BIT : `UHFC_LAST_DATA;

  always @* begin
    tf_take = (t_st == S_IDLE) && tf_valid && cts_ok;
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      t_st   <= S_IDLE;
      t_cnt  <= {DIV_W{1'b0}};
      t_bit  <= 4'h0;
      t_sh   <= 9'h1ff;
      ser_tx <= 1'b1;
    end else begin
      t_cnt <= t_tick ? baud_div - 1'b1 : t_cnt - 1'b1;
      case (t_st)
        S_IDLE: begin
          ser_tx <= 1'b1;
          if (tf_take) begin
            // Parity rides as ninth bit
            t_sh  <= {^tf_data ^ parity_odd, tf_data};
            t_cnt <= baud_div - 1'b1;
            t_st  <= S_STRT;
            ser_tx <= 1'b0;
          end
        end
        S_STRT: begin
          if (t_tick) begin
            ser_tx <= t_sh[0];
            t_sh   <= {1'b1, t_sh[8:1]};
            t_bit  <= 4'h0;
            t_st   <= S_DATA;
          end
        end
        S_DATA: begin
          if (t_tick) begin
            if (t_bit == t_last) begin
              ser_tx <= 1'b1;
              t_st   <= S_STOP;
            end else begin
              ser_tx <= t_sh[0];
              t_sh   <= {1'b1, t_sh[8:1]};
              t_bit  <= t_bit + 1'b1;
            end
          end
        end
        S_STOP: begin
          if (t_tick) begin
            t_st <= S_IDLE;
          end
        end
        default: t_st <= S_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Receiver; bit 8 of the FIFO word flags a parity error
  // -----------------------------------------------------------------
  reg [3:0]       r_st;
  reg [DIV_W-1:0] r_cnt;
  reg [3:0]       r_bit;
  reg [8:0]       r_sh;
  reg [8:0]       rf_in;
  reg             rf_push;
  wire            rf_ready;
  wire [8:0]      rf_data;
  wire            rf_valid;
  wire            r_tick = (r_cnt == {DIV_W{1'b0}});
  wire [3:0]      r_last = parity_en ? `UHFC_PAR_BIT : `UHFC_LAST_DATA;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r_st    <= S_IDLE;
      r_cnt   <= {DIV_W{1'b0}};
      r_bit   <= 4'h0;
      r_sh    <= 9'h000;
      rf_in   <= 9'h000;
      rf_push <= 1'b0;
    end else begin
      rf_push <= 1'b0;
      r_cnt   <= r_tick ? r_cnt : r_cnt - 1'b1;
      case (r_st)
        S_IDLE: begin
          if (!rxd) begin
            // Sample mid-bit
            r_cnt <= {1'b0, baud_div[DIV_W-1:1]};
            r_st  <= S_STRT;
          end
        end
        S_STRT: begin
          if (r_tick) begin
            r_cnt <= baud_div - 1'b1;
            r_bit <= 4'h0;
            r_st  <= rxd ? S_IDLE : S_DATA;  // Glitch rejected
          end
        end
        S_DATA: begin
          if (r_tick) begin
            r_cnt <= baud_div - 1'b1;
            r_sh  <= {rxd, r_sh[8:1]};
            r_bit <= r_bit + 1'b1;
            if (r_bit == r_last) begin
              r_st <= S_STOP;
            end
          end
        end
        S_STOP: begin
          if (r_tick) begin
            r_st <= S_IDLE;
            if (rxd) begin
              rf_push <= 1'b1;
              if (parity_en) begin
                rf_in <= {^r_sh ^ parity_odd, r_sh[7:0]};
              end else begin
                rf_in <= {1'b0, r_sh[8:1]};
              end
            end
          end
        end
        default: r_st <= S_IDLE;
      endcase
    end
  end

  // Full FIFO drops the character; rts_n should have held the host off
  uhfc_fifo #(.WIDTH(9)) u_rxf (
    .mclk(mclk), .rst_n(rst_n),
    .in_data(rf_in), .in_valid(rf_push), .in_ready(rf_ready),
    .out_data(rf_data), .out_valid(rf_valid), .out_ready(!rx_valid || rx_ready)
  );

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data  <= 9'h000;
      rx_valid <= 1'b0;
      rts_n    <= 1'b0;
    end else begin
      if (!rx_valid || rx_ready) begin
        rx_valid <= rf_valid;
        rx_data  <= rf_data;
      end
      // Deassert while room is tight, leaving slack for one in flight
      rts_n <= !rf_ready || (rf_valid && rx_valid && !rx_ready);
    end
  end
endmodule // uhfc_port

// -----------------------------------------------------------------
// Top: two independent ports
// -----------------------------------------------------------------
module uhfc_uart #(
  parameter DIV_W = `UHFC_DIV_W
) (
  input  wire               mclk,
  input  wire               rst_n,
  input  wire [2*DIV_W-1:0] baud_div,
  input  wire [1:0]         parity_en,
  input  wire [1:0]         parity_odd,
  input  wire [15:0]        tx_data,
  input  wire [1:0]         tx_valid,
  output wire [1:0]         tx_ready,
  output wire [17:0]        rx_data,
  output wire [1:0]         rx_valid,
  input  wire [1:0]         rx_ready,
  output wire [1:0]         ser_tx,
  output wire [1:0]         ser_tx_oe,
  input  wire [1:0]         ser_rx,
  output wire [1:0]         ser_rx_pu,
  output wire [1:0]         rts_n,
  input  wire [1:0]         cts_n,
  output wire [1:0]         cts_pd
);
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_port
      uhfc_port #(.DIV_W(DIV_W)) u_port (
        .mclk(mclk), .rst_n(rst_n),
        .baud_div(baud_div[g*DIV_W +: DIV_W]),
        .parity_en(parity_en[g]), .parity_odd(parity_odd[g]),
        .tx_data(tx_data[g*8 +: 8]), .tx_valid(tx_valid[g]),
        .tx_ready(tx_ready[g]),
        .rx_data(rx_data[g*9 +: 9]), .rx_valid(rx_valid[g]),
        .rx_ready(rx_ready[g]),
        .ser_tx(ser_tx[g]), .ser_tx_oe(ser_tx_oe[g]),
        .ser_rx(ser_rx[g]), .ser_rx_pu(ser_rx_pu[g]),
        .rts_n(rts_n[g]), .cts_n(cts_n[g]), .cts_pd(cts_pd[g])
      );
    end
  endgenerate
endmodule // uhfc_uart
`default_nettype wire

// File: uhfc_defs.vh
// Constants for the flow-controlled serial port
`ifndef UHFC_DEFS_VH
`define UHFC_DEFS_VH
`define UHFC_CLK_HZ      100000000
`define UHFC_BAUD_MAX    1000000
`define UHFC_DIV_DEF     16'h0064
`define UHFC_DIV_W       16
`define UHFC_BITS        4
`define UHFC_FIFO_DEPTH  4
`define UHFC_FIFO_AW     2
`define UHFC_LAST_DATA   4'h7
`define UHFC_PAR_BIT     4'h8
`endif

// File: uhfc_checker.sv
// Concurrent checks on the pins of the serial port top
`timescale 1ns/10ps
`default_nettype none
module uhfc_checker (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [1:0]  parity_en,
  input wire logic [17:0] rx_data,
  input wire logic [1:0]  rx_valid,
  input wire logic [1:0]  rx_ready,
  input wire logic [1:0]  ser_tx,
  input wire logic [1:0]  ser_tx_oe,
  input wire logic [1:0]  ser_rx_pu,
  input wire logic [1:0]  rts_n,
  input wire logic [1:0]  cts_pd
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Bench runs eight or more cycles per bit
  sequence s_start; $fell(ser_tx[0]); endsequence
  sequence s_low; !ser_tx[0] [*8]; endsequence
  AST_START: assert property (s_start |-> s_low)
    else $error("start bit too short");
  AST_OE: assert property (ser_tx_oe == 2'b11)
    else $error("tx pin not driven");
  AST_PU: assert property (ser_rx_pu == 2'b11)
    else $error("rx pull-up off");
  AST_PD: assert property (cts_pd == 2'b11)
    else $error("cts pull-down off");
  AST_RESET: assert property ($rose(rst_n) |-> ser_tx == 2'b11 && rts_n == 2'b00)
    else $error("pin levels wrong after reset");
  AST_HOLD0: assert property (rx_valid[0] && !rx_ready[0] |=> rx_valid[0] && $stable(rx_data[8:0]))
    else $error("port 0 rx word not held");
  AST_HOLD1: assert property (rx_valid[1] && !rx_ready[1] |=> rx_valid[1] && $stable(rx_data[17:9]))
    else $error("port 1 rx word not held");
  AST_FREE: assert property (rx_valid[0] && rx_ready[0] && rts_n[0] |-> ##[1:6] !rts_n[0])
    else $error("rts stays high after a pop");
  AST_NOPAR: assert property (!parity_en[0] && rx_valid[0] |-> !rx_data[8])
    else $error("parity flag with parity off");
endmodule // uhfc_checker
`default_nettype wire

// File: uhfc_host.sv
// Behavioural host serial controller on the far side of port 0
`timescale 1ns/10ps
`default_nettype none
module uhfc_host (
  input wire logic  mclk,
  input wire logic  rx_line,
  input wire logic  rts_n,
  output var logic  tx_line
);
  // ---------------------------------------------------------------
  // Sender and receiver
  // ---------------------------------------------------------------
  logic [8:0] got;
  int         n_got;
  int         nb;
  int         div;
  initial begin
    tx_line = 1'b1;
    n_got = 0;
    nb = 8;
    div = 10;
  end
  // Start only while the device asks for data
  task automatic send(input logic [8:0] v);
    while (rts_n !== 1'b0) @(negedge mclk);
    tx_line = 1'b0;
    repeat (div) @(negedge mclk);
    for (int i = 0; i < nb; i++) begin
      tx_line = v[i];
      repeat (div) @(negedge mclk);
    end
    tx_line = 1'b1;
    repeat (div) @(negedge mclk);
  endtask
  always begin
    @(negedge rx_line);
    got = 9'h000;
    repeat (div / 2) @(posedge mclk);
    for (int i = 0; i < nb; i++) begin
      repeat (div) @(posedge mclk);
      got[i] = rx_line;
    end
    repeat (div) @(posedge mclk);
    if (rx_line === 1'b1) n_got++;
  end
endmodule // uhfc_host
`default_nettype wire

// File: uhfc_uart_tb_top.sv
// Self-checking bench for the two-port serial block
`timescale 1ns/10ps
`default_nettype none
module uhfc_uart_tb_top;
  logic        mclk, rst_n;
  logic [31:0] baud_div;
  logic [1:0]  parity_en, parity_odd, tx_valid, rx_ready, cts_n;
  logic [15:0] tx_data;
  wire  [1:0]  tx_ready, rx_valid, ser_tx, ser_tx_oe, ser_rx;
  wire  [1:0]  ser_rx_pu, rts_n, cts_pd;
  wire  [17:0] rx_data;
  wire         host_tx;
  int          err_total, comparisons;
  // Port 1 loops back on itself
  assign ser_rx = {ser_tx[1], host_tx};
  uhfc_uart uhfc_uart_i (.mclk(mclk), .rst_n(rst_n), .baud_div(baud_div),
    .parity_en(parity_en), .parity_odd(parity_odd), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .ser_tx(ser_tx),
    .ser_tx_oe(ser_tx_oe), .ser_rx(ser_rx), .ser_rx_pu(ser_rx_pu),
    .rts_n(rts_n), .cts_n(cts_n), .cts_pd(cts_pd));
  uhfc_host uhfc_host_i (.mclk(mclk), .rx_line(ser_tx[0]),
    .rts_n(rts_n[0]), .tx_line(host_tx));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic push(input int g, input logic [7:0] v);
    while (tx_ready[g] !== 1'b1) @(negedge mclk);
    tx_data[8*g +: 8] = v;
    tx_valid[g] = 1'b1;
    @(negedge mclk);
    tx_valid[g] = 1'b0;
  endtask
  task automatic pop(input int g, input logic [8:0] e);
    for (int k = 0; k < 3000 && rx_valid[g] !== 1'b1; k++) @(negedge mclk);
    chk("rx_data", e, rx_data[9*g +: 9]);
    rx_ready[g] = 1'b1;
    @(negedge mclk);
    rx_ready[g] = 1'b0;
  endtask
  task automatic wait_host(input int n);
    for (int k = 0; k < 3000 && uhfc_host_i.n_got < n; k++) @(negedge mclk);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk("ser_tx", 9'h003, {7'h00, ser_tx});
    chk("rts_n", 9'h000, {7'h00, rts_n});
    chk("tx_ready", 9'h003, {7'h00, tx_ready});
  endtask
  task automatic t_tx;
    push(0, 8'ha5);
    push(0, 8'h3c);
    wait_host(1);
    chk("host_rx", 9'h0a5, uhfc_host_i.got);
    wait_host(2);
    chk("host_rx", 9'h03c, uhfc_host_i.got);
  endtask
  task automatic t_cts;
    int n;
    n = 0;
    cts_n[0] = 1'b1;
    // Let the two-stage sync see the hold-off before the first push
    repeat (4) @(negedge mclk);
    for (int i = 0; i < 6; i++) begin
      if (tx_ready[0] === 1'b1) begin
        push(0, 8'h5a + i);
        n++;
      end else @(negedge mclk);
    end
    repeat (300) @(negedge mclk);
    chk("tx_accepted", 9'h004, n[8:0]);
    chk("ser_tx_held", 9'h001, {8'h00, ser_tx[0]});
    cts_n[0] = 1'b0;
    wait_host(6);
    chk("host_rx", 9'h05d, uhfc_host_i.got);
  endtask
  task automatic t_par;
    parity_en = 2'b11;
    parity_odd = 2'b10;
    uhfc_host_i.nb = 9;
    push(0, 8'h83);
    wait_host(7);
    chk("host_rx", {^8'h83, 8'h83}, uhfc_host_i.got);
    uhfc_host_i.send({^8'h96, 8'h96});
    pop(0, 9'h096);
    uhfc_host_i.send({~^8'h96, 8'h96});
    pop(0, 9'h196);
    push(1, 8'h71);
    pop(1, 9'h071);
    parity_en = 2'b00;
    uhfc_host_i.nb = 8;
  endtask
  task automatic t_fill;
    fork
      for (int i = 0; i < 7; i++) uhfc_host_i.send(9'h040 + i);
    join_none
    repeat (900) @(negedge mclk);
    chk("rts_full", 9'h001, {8'h00, rts_n[0]});
    for (int i = 0; i < 7; i++) pop(0, 9'h040 + i);
  endtask
  // ---------------------------------------------------------------
  // Run
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    {rst_n, parity_en, parity_odd, tx_valid, rx_ready, cts_n} = 11'h000;
    {err_total, comparisons} = 64'h0;
    baud_div = 32'h000a000a;
    tx_data = 16'h0000;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    t_reset();
    t_tx();
    t_cts();
    t_par();
    t_fill();
    tally_and_finish();
  end
endmodule // uhfc_uart_tb_top
bind uhfc_uart uhfc_checker uhfc_checker_i (.mclk(mclk), .rst_n(rst_n),
  .parity_en(parity_en), .rx_data(rx_data), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .ser_tx(ser_tx), .ser_tx_oe(ser_tx_oe),
  .ser_rx_pu(ser_rx_pu), .rts_n(rts_n), .cts_pd(cts_pd));
`default_nettype wire
